// >>> src/kbh_defs.vh
// Constants for the keyboard host port and fast reset/A20 register
`ifndef KBH_DEFS_VH
`define KBH_DEFS_VH
// Host I/O addresses (low byte)
`define KBH_ADDR_DATA 8'h60
`define KBH_ADDR_CMD 8'h64
`define KBH_ADDR_FAST 8'h92
// Status register fields
`define KBH_ST_OBF 0
`define KBH_ST_IBF 1
`define KBH_ST_CD 3
`define KBH_HOST_CD_ADDR_BIT 2
`define KBH_ST_RESET 8'h00
`define KBH_ST_USER_MASK 8'hF4
// Fast reset/A20 register
`define KBH_FAST_RESET 8'h24
`define KBH_FAST_FIXED 8'h24
`define KBH_FAST_RST_BIT 0
`define KBH_FAST_A20_BIT 1
// Configuration register bit that enables the fast register
`define KBH_CFG_FAST_EN_BIT 2
// Alternate reset timing
`define KBH_CLK_PERIOD_PS 5000
`define KBH_ALT_DELAY_NS 500
`define KBH_ALT_PULSE_NS 1000
`endif

// >>> src/kbh_pulse_gen.v
// Delayed fixed-width active-low pulse generator for the alternate reset
`timescale 1ns/1ps
module kbh_pulse_gen #(
    parameter DELAY_CYC = 100,
    parameter PULSE_CYC = 200,
    parameter CW = 16
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire start_i,
    output reg pulse_n_o
);
    localparam S_IDLE = 3'b001;
    localparam S_WAIT = 3'b010;
    localparam S_PULSE = 3'b100;
    localparam integer DLY_M1 = DELAY_CYC - 1;
    localparam integer PLS_M1 = PULSE_CYC - 1;
    localparam [CW-1:0] DLY_LAST = DLY_M1[CW-1:0];
    localparam [CW-1:0] PLS_LAST = PLS_M1[CW-1:0];
    localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

    reg [2:0] state_r;
    reg [CW-1:0] cnt_r;

    // ----------------------------------------
    // Delay then pulse sequencer
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= S_IDLE;
            cnt_r <= {CW{1'b0}};
            pulse_n_o <= 1'b1;
        end else begin
            case (state_r)
                S_IDLE: begin
                    cnt_r <= {CW{1'b0}};
                    pulse_n_o <= 1'b1;
                    if (start_i) begin
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (cnt_r == DLY_LAST) begin // [RULE_16]
                        cnt_r <= {CW{1'b0}};
                        pulse_n_o <= 1'b0;
                        state_r <= S_PULSE;
                    end else begin
                        cnt_r <= cnt_r + CNT_ONE;
                    end
                end
                S_PULSE: begin
                    if (cnt_r == PLS_LAST) begin // [RULE_16]
                        pulse_n_o <= 1'b1;
                        state_r <= S_IDLE;
                    end else begin
                        cnt_r <= cnt_r + CNT_ONE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                    pulse_n_o <= 1'b1;
                end
            endcase
        end
    end
endmodule

// >>> src/kbh_host_port.v
// Keyboard controller host mailbox with fast reset/A20 register
// Functional notes
// [RULE_01] Embedded write of data loads host read buffer, sets output-full, may raise irq.
// [RULE_02] Embedded read returns host byte, clears input-full and its interrupt.
// [RULE_03] Status: bit0 output-full, bit1 input-full, bit3 command/data, rest user bits.
// [RULE_04] Status is read-only to host, read/write to embedded CPU.
// [RULE_05] Reset clears status to zero; data register has no reset value.
// [RULE_06] Host write sets command/data bit from host address bit 2.
// [RULE_07] Host write sets input-full and raises input-full interrupt if enabled.
// [RULE_08] Output-full set by embedded write, cleared when host reads data.
// [RULE_09] Controller runs from 12 MHz clock derived from 14.318 MHz reference.
// [RULE_10] Reset source holds reset at least 24 controller clock periods.
// [RULE_11] Fast register answers host only while config bit 2 is set.
// [RULE_12] Fast register is 8 bits at 92h, default 24h, drives reset and A20.
// [RULE_13] Reserved bits read fixed: 7:6 zero, 5 one, 4:3 zero, 2 one.
// [RULE_14] Bit 1 written 0 drives alternate A20 low, 1 drives it high.
// [RULE_15] System reset clears bit 0, alternate reset output inactive.
// [RULE_16] Writing bit 0 high pulses reset low at least 1 us after 500 ns.
// [RULE_17] No new pulse until bit 0 has been written back to zero.
// [RULE_18] With flags enabled and port bit 24 high, output-full drives keyboard irq.
// [RULE_19] With flags enabled and port bit 25 high, inverted input-full drives mouse irq.
// [RULE_20] Delay and pulse width come from counters on the block clock.
`timescale 1ns/1ps
`include "kbh_defs.vh"
module kbh_host_port #(
    parameter CW = 16
) (
    input wire CLOCK_I,
    input wire RST_B_I,
    // Host side
    input wire HOST_WR_I,
    input wire HOST_RD_I,
    input wire [7:0] HOST_ADDR_I,
    input wire [7:0] HOST_WDATA_I,
    output reg [7:0] HOST_RDATA_O,
    output reg HOST_RVALID_O,
    // Embedded controller side
    input wire EMB_DATA_WR_I,
    input wire EMB_DATA_RD_I,
    input wire EMB_STATUS_WR_I,
    input wire [7:0] EMB_WDATA_I,
    input wire EMB_FLAGS_EN_I,
    input wire KBD_IRQ_PORT_BIT_I,
    input wire MOUSE_IRQ_PORT_BIT_I,
    input wire [7:0] KBD_RESET_A20_CONFIG_I,
    output reg [7:0] EMB_DATA_O,
    output reg [7:0] EMB_STATUS_O,
    output reg INPUT_FULL_IRQ_N_O,
    // System outputs
    output reg KEYBOARD_IRQ_OUT_O,
    output reg MOUSE_IRQ_OUT_O,
    output reg ALTERNATE_A20_O,
    output wire ALTERNATE_RESET_N_O
);
    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    // Least times: round up to whole cycles
    localparam DELAY_CYC = (`KBH_ALT_DELAY_NS * 1000 + `KBH_CLK_PERIOD_PS - 1) / `KBH_CLK_PERIOD_PS;
    localparam PULSE_CYC = (`KBH_ALT_PULSE_NS * 1000 + `KBH_CLK_PERIOD_PS - 1) / `KBH_CLK_PERIOD_PS;

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    // Reset length from the source is the source's duty; here it is only synchronised
    reg rst_meta_r;
    reg rst_sync_r;
    always @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire rst_n = rst_sync_r;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire fast_en = KBD_RESET_A20_CONFIG_I[`KBH_CFG_FAST_EN_BIT];
    wire host_data_wr = HOST_WR_I && (HOST_ADDR_I == `KBH_ADDR_DATA);
    wire host_cmd_wr = HOST_WR_I && (HOST_ADDR_I == `KBH_ADDR_CMD);
    wire host_in_wr = host_data_wr || host_cmd_wr;
    wire host_data_rd = HOST_RD_I && (HOST_ADDR_I == `KBH_ADDR_DATA);
    wire host_stat_rd = HOST_RD_I && (HOST_ADDR_I == `KBH_ADDR_CMD);
    wire fast_hit = HOST_ADDR_I == `KBH_ADDR_FAST;
    wire fast_wr = HOST_WR_I && fast_hit && fast_en; // [RULE_11]
    wire fast_rd = HOST_RD_I && fast_hit && fast_en; // [RULE_11]

    // ----------------------------------------
    // Mailbox storage
    // ----------------------------------------
    // Data buffers are not reset; software must not trust them before a full flag
    reg [7:0] in_buf_r;
    reg [7:0] out_buf_r;
    always @(posedge CLOCK_I) begin
        if (host_in_wr) begin
            in_buf_r <= HOST_WDATA_I; // [RULE_05]
        end
        if (EMB_DATA_WR_I) begin
            out_buf_r <= EMB_WDATA_I; // [RULE_01]
        end
    end

    // ----------------------------------------
    // Status register
    // ----------------------------------------
    reg [7:0] status_r;
    reg [7:0] status_nxt;
    always @* begin
        status_nxt = status_r;
        if (EMB_STATUS_WR_I) begin
            // Only user bits are writable by the embedded CPU
            status_nxt = (status_r & ~`KBH_ST_USER_MASK) | (EMB_WDATA_I & `KBH_ST_USER_MASK); // [RULE_03]
        end
        // Clears first so that same-cycle sets win
        if (EMB_DATA_RD_I) begin
            status_nxt[`KBH_ST_IBF] = 1'b0; // [RULE_02]
        end
        if (host_data_rd) begin
            status_nxt[`KBH_ST_OBF] = 1'b0; // [RULE_08]
        end
        if (host_in_wr) begin
            status_nxt[`KBH_ST_IBF] = 1'b1; // [RULE_07]
            status_nxt[`KBH_ST_CD] = HOST_ADDR_I[`KBH_HOST_CD_ADDR_BIT]; // [RULE_06]
        end
        if (EMB_DATA_WR_I) begin
            status_nxt[`KBH_ST_OBF] = 1'b1; // [RULE_01] [RULE_08]
        end
    end

    always @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= `KBH_ST_RESET; // [RULE_05]
        end else begin
            status_r <= status_nxt;
        end
    end

    // ----------------------------------------
    // Fast reset / A20 register
    // ----------------------------------------
    reg fast_rst_bit_r;
    reg fast_a20_bit_r;
    reg pulse_armed_r;
    reg pulse_start_r;
    always @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            fast_rst_bit_r <= 1'b0; // [RULE_15]
            fast_a20_bit_r <= 1'b0;
            pulse_armed_r <= 1'b1;
            pulse_start_r <= 1'b0;
        end else begin
            pulse_start_r <= 1'b0;
            if (fast_wr) begin
                fast_rst_bit_r <= HOST_WDATA_I[`KBH_FAST_RST_BIT];
                fast_a20_bit_r <= HOST_WDATA_I[`KBH_FAST_A20_BIT]; // [RULE_14]
                if (!HOST_WDATA_I[`KBH_FAST_RST_BIT]) begin
                    pulse_armed_r <= 1'b1; // [RULE_17]
                end else if (pulse_armed_r) begin
                    // One pulse per 0-to-1 sequence; repeated 1 writes are ignored
                    pulse_start_r <= 1'b1; // [RULE_16]
                    pulse_armed_r <= 1'b0; // [RULE_17]
                end
            end
        end
    end

    kbh_pulse_gen #(
        .DELAY_CYC(DELAY_CYC),
        .PULSE_CYC(PULSE_CYC),
        .CW(CW)
    ) u_pulse (
        .clk_i(CLOCK_I),
        .rst_n_i(rst_n),
        .start_i(pulse_start_r),
        .pulse_n_o(ALTERNATE_RESET_N_O)
    ); // [RULE_20]

    wire [7:0] fast_read = `KBH_FAST_FIXED | {6'h00, fast_a20_bit_r, fast_rst_bit_r}; // [RULE_12] [RULE_13]

    // ----------------------------------------
    // Host read data
    // ----------------------------------------
    always @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            HOST_RDATA_O <= 8'h00;
            HOST_RVALID_O <= 1'b0;
        end else begin
            HOST_RVALID_O <= host_data_rd || host_stat_rd || fast_rd;
            if (host_data_rd) begin
                HOST_RDATA_O <= out_buf_r;
            end else if (host_stat_rd) begin
                HOST_RDATA_O <= status_r; // [RULE_04]
            end else if (fast_rd) begin
                HOST_RDATA_O <= fast_read;
            end else begin
                HOST_RDATA_O <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // Embedded side and interrupt outputs
    // ----------------------------------------
    // Status, input-full irq and flag-enabled keyboard/mouse irqs register status_nxt so they match status_r with no lag; data and A20 follow one cycle later
    always @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            EMB_DATA_O <= 8'h00;
            EMB_STATUS_O <= `KBH_ST_RESET;
            INPUT_FULL_IRQ_N_O <= 1'b1;
            KEYBOARD_IRQ_OUT_O <= 1'b0;
            MOUSE_IRQ_OUT_O <= 1'b0;
            ALTERNATE_A20_O <= 1'b0;
        end else begin
            EMB_DATA_O <= in_buf_r; // [RULE_02]
            EMB_STATUS_O <= status_nxt; // [RULE_04]
            INPUT_FULL_IRQ_N_O <= ~status_nxt[`KBH_ST_IBF]; // [RULE_07] [RULE_02]
            ALTERNATE_A20_O <= fast_a20_bit_r; // [RULE_14]
            if (EMB_FLAGS_EN_I) begin
                KEYBOARD_IRQ_OUT_O <= KBD_IRQ_PORT_BIT_I & status_nxt[`KBH_ST_OBF]; // [RULE_18] [RULE_01]
                if (MOUSE_IRQ_PORT_BIT_I) begin
                    MOUSE_IRQ_OUT_O <= ~status_nxt[`KBH_ST_IBF]; // [RULE_19]
                end else begin
                    MOUSE_IRQ_OUT_O <= 1'b0;
                end
            end else begin
                KEYBOARD_IRQ_OUT_O <= KBD_IRQ_PORT_BIT_I;
                MOUSE_IRQ_OUT_O <= MOUSE_IRQ_PORT_BIT_I; // [RULE_19]
            end
        end
    end
    // Clock is the system's 200 MHz; the 12 MHz controller clock is made outside. [RULE_09]
endmodule

// >>> dv/kbh_host_port_assertions.sv
// Concurrent checks on the keyboard host port pins
`timescale 1ns/1ps
module kbh_host_port_assertions (
    input wire CLOCK_I,
    input wire RST_B_I,
    input wire HOST_WR_I,
    input wire HOST_RD_I,
    input wire [7:0] HOST_ADDR_I,
    input wire [7:0] HOST_WDATA_I,
    input wire [7:0] HOST_RDATA_O,
    input wire HOST_RVALID_O,
    input wire EMB_DATA_WR_I,
    input wire EMB_DATA_RD_I,
    input wire EMB_FLAGS_EN_I,
    input wire KBD_IRQ_PORT_BIT_I,
    input wire MOUSE_IRQ_PORT_BIT_I,
    input wire [7:0] KBD_RESET_A20_CONFIG_I,
    input wire [7:0] EMB_STATUS_O,
    input wire INPUT_FULL_IRQ_N_O,
    input wire KEYBOARD_IRQ_OUT_O,
    input wire MOUSE_IRQ_OUT_O,
    input wire ALTERNATE_A20_O,
    input wire ALTERNATE_RESET_N_O
);
default clocking @(posedge CLOCK_I); endclocking
default disable iff (!RST_B_I);
wire kb_dec = HOST_ADDR_I == 8'h60 || HOST_ADDR_I == 8'h64;
wire fast_en = HOST_ADDR_I == 8'h92 && KBD_RESET_A20_CONFIG_I[2];
reg [7:0] low_cnt_r;
reg [7:0] since_r;
// -----------------------------
// Pulse timing helpers
// -----------------------------
// since_r saturates so a long idle spell cannot wrap into a false short delay; low_cnt_r wraps
always @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
        low_cnt_r <= 8'h00;
        since_r <= 8'hFF;
    end else begin
        low_cnt_r <= ALTERNATE_RESET_N_O ? 8'h00 : low_cnt_r + 8'h01;
        since_r <= (HOST_WR_I && fast_en && HOST_WDATA_I[0]) ? 8'h00 : since_r + {7'h0, since_r != 8'hFF};
    end
end
sequence host_rd_s; HOST_RD_I && kb_dec; endsequence
sequence fast_wr_s; HOST_WR_I && fast_en; endsequence
rd_answer_a: assert property (host_rd_s |=> HOST_RVALID_O) else $error("read not answered");
status_read_a: assert property (HOST_RD_I && HOST_ADDR_I == 8'h64 |=> HOST_RDATA_O == $past(EMB_STATUS_O))
    else $error("status read wrong");
ibf_set_a: assert property (HOST_WR_I && kb_dec |=> EMB_STATUS_O[1] && !INPUT_FULL_IRQ_N_O)
    else $error("input full not set");
cd_bit_a: assert property (HOST_WR_I && kb_dec |=> EMB_STATUS_O[3] == $past(HOST_ADDR_I[2]))
    else $error("command bit wrong");
obf_set_a: assert property (EMB_DATA_WR_I |=> EMB_STATUS_O[0]) else $error("output full not set");
obf_clear_a: assert property (HOST_RD_I && HOST_ADDR_I == 8'h60 && !EMB_DATA_WR_I |=> !EMB_STATUS_O[0])
    else $error("output full not cleared");
ibf_clear_a: assert property (EMB_DATA_RD_I && !HOST_WR_I |=> !EMB_STATUS_O[1] && INPUT_FULL_IRQ_N_O)
    else $error("input full not cleared");
keyboard_irq_out_gate_a: assert property (EMB_FLAGS_EN_I |=> KEYBOARD_IRQ_OUT_O == ($past(KBD_IRQ_PORT_BIT_I) && EMB_STATUS_O[0]))
    else $error("keyboard irq wrong");
mouse_irq_out_gate_a: assert property (EMB_FLAGS_EN_I && MOUSE_IRQ_PORT_BIT_I |=> MOUSE_IRQ_OUT_O == !EMB_STATUS_O[1])
    else $error("mouse irq wrong");
a20_drive_a: assert property (fast_wr_s |-> ##2 ALTERNATE_A20_O == $past(HOST_WDATA_I[1], 2))
    else $error("a20 wrong");
fast_refuse_a: assert property (HOST_RD_I && HOST_ADDR_I == 8'h92 && !KBD_RESET_A20_CONFIG_I[2] |=> !HOST_RVALID_O)
    else $error("disabled fast read answered");
fast_fixed_a: assert property (HOST_RD_I && fast_en |=> HOST_RVALID_O && (HOST_RDATA_O & 8'hFC) == 8'h24)
    else $error("fast fixed bits wrong");
rst_delay_a: assert property ($fell(ALTERNATE_RESET_N_O) |-> since_r >= 8'h64) else $error("reset pulse early");
rst_width_a: assert property ($rose(ALTERNATE_RESET_N_O) |-> low_cnt_r == 8'hC8) else $error("reset pulse width");
endmodule
bind kbh_host_port kbh_host_port_assertions chk (.*);

// >>> dv/kbh_emb_model.sv
// Embedded controller model that drains each host byte
`timescale 1ns/1ps
module kbh_emb_model (
    input wire clk_i,
    input wire irq_n_i,
    input wire slow_i,
    input wire [7:0] data_i,
    output reg rd_o,
    output reg got_o,
    output reg [7:0] byte_o
);
integer cnt = 0;
initial begin
    rd_o = 1'b0;
    got_o = 1'b0;
    byte_o = 8'h00;
end
// Polls the interrupt like firmware, so it never reads an empty buffer
always @(posedge clk_i) begin
    got_o <= 1'b0;
    if (rd_o) begin
        rd_o <= #1 1'b0;
        got_o <= 1'b1;
        byte_o <= data_i;
        cnt <= 0;
    end else if (irq_n_i !== 1'b0) begin
        cnt <= 0;
    end else if (cnt >= (slow_i ? 20 : 1)) begin
        rd_o <= #1 1'b1;
    end else begin
        cnt <= cnt + 1;
    end
end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the keyboard host port
`timescale 1ns/1ps
module tb;
reg CLOCK_I = 0, RST_B_I = 0, HOST_WR_I = 0, HOST_RD_I = 0, EMB_DATA_WR_I = 0, EMB_STATUS_WR_I = 0;
reg EMB_FLAGS_EN_I = 0, KBD_IRQ_PORT_BIT_I = 0, MOUSE_IRQ_PORT_BIT_I = 0, slow = 0;
reg [7:0] HOST_ADDR_I = 8'h00, HOST_WDATA_I = 8'h00, EMB_WDATA_I = 8'h00, KBD_RESET_A20_CONFIG_I = 8'h00, d;
wire [7:0] HOST_RDATA_O, EMB_DATA_O, EMB_STATUS_O, got_byte;
wire HOST_RVALID_O, EMB_DATA_RD_I, INPUT_FULL_IRQ_N_O, KEYBOARD_IRQ_OUT_O, MOUSE_IRQ_OUT_O;
wire ALTERNATE_A20_O, ALTERNATE_RESET_N_O, got;
integer n_errors = 0, checked = 0, seed = 89044, i, k, n;
reg [7:0] host_q[$];
reg [7:0] emb_q[$];
kbh_host_port uut (.*);
kbh_emb_model emb (.clk_i(CLOCK_I), .irq_n_i(INPUT_FULL_IRQ_N_O), .slow_i(slow), .data_i(EMB_DATA_O),
    .rd_o(EMB_DATA_RD_I), .got_o(got), .byte_o(got_byte));
initial begin
    forever #2.5 CLOCK_I = ~CLOCK_I;
end
// ---------------------------------
// Bus tasks and result checking
// ---------------------------------
task chk(input string nm, input [7:0] e, input [7:0] g);
    checked++;
    if (g !== e) begin
        n_errors++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
endtask
task step(input integer c);
    repeat (c) @(posedge CLOCK_I);
    #1;
endtask
task hw(input [7:0] a, input [7:0] v);
    @(posedge CLOCK_I);
    #1 HOST_WR_I = 1; HOST_ADDR_I = a; HOST_WDATA_I = v;
    @(posedge CLOCK_I);
    #1 HOST_WR_I = 0;
endtask
// Expected answer is queued only when the access should be decoded
task hr(input [7:0] a, input [7:0] e, input p);
    if (p) host_q.push_back(e);
    @(posedge CLOCK_I);
    #1 HOST_RD_I = 1; HOST_ADDR_I = a;
    @(posedge CLOCK_I);
    #1 HOST_RD_I = 0;
endtask
task ew(input s, input [7:0] v);
    @(posedge CLOCK_I);
    #1 EMB_DATA_WR_I = !s; EMB_STATUS_WR_I = s; EMB_WDATA_I = v;
    @(posedge CLOCK_I);
    #1 EMB_DATA_WR_I = 0; EMB_STATUS_WR_I = 0;
endtask
task wrap_up;
    $display("compares %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
always @(negedge CLOCK_I) begin
    if (HOST_RVALID_O === 1'b1) begin
        if (host_q.size() == 0) chk("unexpected host read", 8'h00, 8'hFF);
        else chk("host read data", host_q.pop_front(), HOST_RDATA_O);
    end
    if (got === 1'b1) chk("embedded read data", emb_q.pop_front(), got_byte);
end
initial begin
    #50000 n_errors++;
    wrap_up;
end
initial begin
    repeat (10) @(posedge CLOCK_I);
    #1 RST_B_I = 1;
    step(3);
    chk("status after reset", 8'h00, EMB_STATUS_O);
    chk("alt pins after reset", 8'h01, {6'h0, ALTERNATE_A20_O, ALTERNATE_RESET_N_O});
    hr(8'h64, 8'h00, 1);
    hr(8'h50, 8'h00, 0);
    $display("test reset done");
    EMB_FLAGS_EN_I = 1; KBD_IRQ_PORT_BIT_I = 1; MOUSE_IRQ_PORT_BIT_I = 1;
    for (i = 0; i < 6; i++) begin
        d = $random(seed); slow = i[1]; emb_q.push_back(d);
        hw(i[0] ? 8'h64 : 8'h60, d);
        step(1);
        chk("write flags", {4'h0, i[0], 3'b010}, {4'h0, EMB_STATUS_O[3], MOUSE_IRQ_OUT_O, EMB_STATUS_O[1], INPUT_FULL_IRQ_N_O});
        n = 0;
        while (INPUT_FULL_IRQ_N_O !== 1'b1 && n < 100) begin step(1); n++; end
        chk("input full cleared", 8'h00, {7'h0, EMB_STATUS_O[1]});
    end
    $display("test host to embedded done");
    for (i = 0; i < 4; i++) begin
        d = $random(seed); KBD_IRQ_PORT_BIT_I = i[0];
        ew(0, d);
        step(1);
        chk("output full and irq", {6'h0, i[0], 1'b1}, {6'h0, KEYBOARD_IRQ_OUT_O, EMB_STATUS_O[0]});
        hr(8'h60, d, 1);
        step(1);
        chk("output full cleared", 8'h00, {6'h0, KEYBOARD_IRQ_OUT_O, EMB_STATUS_O[0]});
        d = $random(seed);
        ew(1, d);
        step(1);
        chk("user bits", (d & 8'hF4) | 8'h08, EMB_STATUS_O);
        hr(8'h64, (d & 8'hF4) | 8'h08, 1);
    end
    $display("test embedded to host done");
    hr(8'h92, 8'h24, 0);
    KBD_RESET_A20_CONFIG_I = $random(seed) | 8'h04;
    hr(8'h92, 8'h24, 1);
    for (k = 0; k < 4; k++) begin
        d = (k == 3) ? 8'h03 : ((k == 2) ? 8'h00 : 8'h01);
        hw(8'h92, d);
        n = 0;
        repeat (420) begin step(1); n += !ALTERNATE_RESET_N_O; end
        chk("reset pulse cycles", (k == 0 || k == 3) ? 8'hC8 : 8'h00, n[7:0]);
        chk("a20 level", {7'h0, d[1]}, {7'h0, ALTERNATE_A20_O});
        hr(8'h92, 8'h24 | d, 1);
    end
    EMB_FLAGS_EN_I = 0; KBD_IRQ_PORT_BIT_I = 1; MOUSE_IRQ_PORT_BIT_I = 0;
    step(2);
    chk("irq follow ports", 8'h02, {6'h0, KEYBOARD_IRQ_OUT_O, MOUSE_IRQ_OUT_O});
    KBD_IRQ_PORT_BIT_I = 0; MOUSE_IRQ_PORT_BIT_I = 1;
    step(2);
    chk("irq follow ports", 8'h01, {6'h0, KEYBOARD_IRQ_OUT_O, MOUSE_IRQ_OUT_O});
    $display("test fast reset done");
    wrap_up;
end
endmodule
